// file: emb_memory_block.sv
// embedded memory block with input/output enable groups, bypassable registers and an AXI4-Lite config slave
`timescale 1ns/1ps

module emb_memory_block (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [emb_pkg::EMB_DATA_W-1:0] wr_data_i,
   input wire logic [emb_pkg::EMB_ADDR_W-1:0] wr_addr_i,
   input wire logic [emb_pkg::EMB_ADDR_W-1:0] rd_addr_i,
   input wire logic write_strobe_local_i,
   input wire logic write_strobe_global_i,
   input wire logic read_strobe_local_i,
   input wire logic read_strobe_global_i,
   input wire logic in_ce_i,
   input wire logic out_ce_i,
   input wire logic in_clr_local_i,
   input wire logic out_clr_local_i,
   input wire logic clr_global_i,
   input wire logic dev_clr_i,
   output logic [emb_pkg::EMB_DATA_W-1:0] rd_data_o,
   input wire logic [emb_pkg::EMB_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [emb_pkg::EMB_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import emb_pkg::*;

   logic [EMB_CTRL_W-1:0] ctrl_q;
   logic in_clr;
   logic out_clr;
   logic [EMB_DATA_W-1:0] wdata_q;
   logic [EMB_ADDR_W-1:0] waddr_q;
   logic [EMB_ADDR_W-1:0] raddr_q;
   logic wstb_q;
   logic rstb_q;
   logic [EMB_DATA_W-1:0] wdata_eff;
   logic [EMB_ADDR_W-1:0] waddr_eff;
   logic [EMB_ADDR_W-1:0] raddr_eff;
   logic wstb_eff;
   logic rstb_eff;
   logic wstb_src;
   logic rstb_src;
   logic [EMB_DATA_W-1:0] mem_q [EMB_DEPTH];
   logic [EMB_DATA_W-1:0] mem_rdata;
   logic [EMB_DATA_W-1:0] rd_data_q;
   logic aw_got_q;
   logic w_got_q;
   logic [EMB_AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_axi_q;
   logic [3:0] wstrb_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // clear sources
   // each group takes its own local clear plus the global and device-wide clears
   assign in_clr = in_clr_local_i | clr_global_i | dev_clr_i;
   assign out_clr = out_clr_local_i | clr_global_i | dev_clr_i;

   assign wstb_src = ctrl_q[EMB_STB_GLOBAL] ? write_strobe_global_i : write_strobe_local_i;
   assign rstb_src = ctrl_q[EMB_STB_GLOBAL] ? read_strobe_global_i : read_strobe_local_i;

   always_ff @(posedge sys_clk_i or posedge in_clr) begin
      if (in_clr) begin
         wdata_q <= '0;
         waddr_q <= '0;
         raddr_q <= '0;
         wstb_q <= 1'b0;
         rstb_q <= 1'b0;
      end else if (reset_i) begin
         wdata_q <= '0;
         waddr_q <= '0;
         raddr_q <= '0;
         wstb_q <= 1'b0;
         rstb_q <= 1'b0;
      end else if (in_ce_i) begin
         wdata_q <= wr_data_i;
         waddr_q <= wr_addr_i;
         raddr_q <= rd_addr_i;
         wstb_q <= wstb_src;
         rstb_q <= rstb_src;
      end
   end

   always_comb begin
      wdata_eff = ctrl_q[EMB_BYP_WDATA] ? wr_data_i : wdata_q;
      waddr_eff = ctrl_q[EMB_BYP_WADDR] ? wr_addr_i : waddr_q;
      raddr_eff = ctrl_q[EMB_BYP_RADDR] ? rd_addr_i : raddr_q;
      wstb_eff = ctrl_q[EMB_BYP_WSTB] ? wstb_src : wstb_q;
      rstb_eff = ctrl_q[EMB_BYP_RSTB] ? rstb_src : rstb_q;
      if (ctrl_q[EMB_SINGLE_PORT]) begin
         raddr_eff = waddr_eff;
      end
   end

   // array write
   // the array itself is not cleared; only the registers around it are
   always_ff @(posedge sys_clk_i) begin
      if (wstb_eff && in_ce_i) begin
         mem_q[waddr_eff] <= wdata_eff;
      end
   end

   assign mem_rdata = mem_q[raddr_eff];

   // output group register
   // bypass keeps the port registered but makes it load on every read strobe, ignoring the output enable
   always_ff @(posedge sys_clk_i or posedge out_clr) begin
      if (out_clr) begin
         rd_data_q <= '0;
      end else if (reset_i) begin
         rd_data_q <= '0;
      end else if (rstb_eff && (ctrl_q[EMB_BYP_RDATA] || out_ce_i)) begin
         rd_data_q <= mem_rdata;
      end
   end

   assign rd_data_o = rd_data_q;

   // register slave: write address and data taken in either order
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         awaddr_q <= '0;
         wdata_axi_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= EMB_RESP_OKAY;
         ctrl_q <= EMB_CTRL_RST;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awaddr_q <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            wdata_axi_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_got_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (aw_got_q && w_got_q && !bvalid_q) begin
            bvalid_q <= 1'b1;
            if (awaddr_q == EMB_CTRL_OFS) begin
               bresp_q <= EMB_RESP_OKAY;
               if (wstrb_q[0]) begin
                  ctrl_q <= wdata_axi_q[EMB_CTRL_W-1:0];
               end
            end else begin
               bresp_q <= EMB_RESP_SLVERR;
            end
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // read side; status shows the live output register
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= EMB_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= EMB_RESP_OKAY;
         if (s_axi_araddr == EMB_CTRL_OFS) begin
            rdata_q <= {EMB_ZERO32[31:EMB_CTRL_W], ctrl_q};
         end else if (s_axi_araddr == EMB_STATUS_OFS) begin
            rdata_q <= {EMB_ZERO32[31:EMB_DATA_W], rd_data_q};
         end else begin
            rdata_q <= EMB_ZERO32;
            rresp_q <= EMB_RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   sequence s_write_issue;
      wstb_eff && in_ce_i && !in_clr;
   endsequence

   property p_write_stores;
      @(posedge sys_clk_i) disable iff (reset_i)
      s_write_issue ##1 1'b1 |-> mem_q[$past(waddr_eff)] == $past(wdata_eff);
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("write did not store data");

   property p_in_capture;
      @(posedge sys_clk_i) disable iff (reset_i || in_clr)
      in_ce_i |=> (waddr_q == $past(wr_addr_i)) && (raddr_q == $past(rd_addr_i));
   endproperty
   a_in_capture: assert property (p_in_capture) else $error("input group missed capture");

   property p_out_update;
      @(posedge sys_clk_i) disable iff (reset_i || out_clr)
      (out_ce_i && rstb_eff) |=> rd_data_q == $past(mem_rdata);
   endproperty
   a_out_update: assert property (p_out_update) else $error("output register did not load");

   property p_out_hold;
      @(posedge sys_clk_i) disable iff (reset_i || out_clr)
      (!out_ce_i && !ctrl_q[EMB_BYP_RDATA]) |=> $stable(rd_data_q);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output register moved while disabled");

   property p_in_clear;
      @(posedge sys_clk_i) disable iff (reset_i)
      in_clr |-> (wdata_q == '0) && !wstb_q && !rstb_q;
   endproperty
   a_in_clear: assert property (p_in_clear) else $error("input group not cleared");

   // read data must come from the write-address word, not just an equal address mux
   property p_single_port;
      @(posedge sys_clk_i) disable iff (reset_i || out_clr)
      (ctrl_q[EMB_SINGLE_PORT] && rstb_eff && out_ce_i) |=> rd_data_q == $past(mem_q[waddr_eff]);
   endproperty
   a_single_port: assert property (p_single_port) else $error("single-port read not from write address");

   property p_bypass_addr;
      @(posedge sys_clk_i) disable iff (reset_i)
      (ctrl_q[EMB_BYP_WADDR] && ctrl_q[EMB_BYP_WDATA] && wstb_eff && in_ce_i)
         |=> mem_q[$past(wr_addr_i)] == $past(wr_data_i);
   endproperty
   a_bypass_addr: assert property (p_bypass_addr) else $error("bypassed write did not store live input");

endmodule : emb_memory_block

// file: emb_pkg.sv
// shared constants for the embedded memory block and its register slave
package emb_pkg;
   localparam int EMB_DATA_W = 16;
   localparam int EMB_ADDR_W = 8;
   localparam int EMB_DEPTH = 256;
   localparam int EMB_AXI_AW = 4;
   localparam logic [EMB_AXI_AW-1:0] EMB_CTRL_OFS = 4'h0;
   localparam logic [EMB_AXI_AW-1:0] EMB_STATUS_OFS = 4'h4;
   // ctrl field positions
   localparam int EMB_BYP_WDATA = 0;
   localparam int EMB_BYP_RDATA = 1;
   localparam int EMB_BYP_RADDR = 2;
   localparam int EMB_BYP_WADDR = 3;
   localparam int EMB_BYP_WSTB = 4;
   localparam int EMB_BYP_RSTB = 5;
   localparam int EMB_SINGLE_PORT = 6;
   localparam int EMB_STB_GLOBAL = 7;
   localparam int EMB_CTRL_W = 8;
   localparam logic [EMB_CTRL_W-1:0] EMB_CTRL_RST = 8'h00;
   localparam logic [1:0] EMB_RESP_OKAY = 2'h0;
   localparam logic [1:0] EMB_RESP_SLVERR = 2'h2;
   localparam logic [31:0] EMB_ZERO32 = 32'h0000_0000;
endpackage : emb_pkg

// file: emb_logic_cell_model.sv
// user logic model that sources the memory block strobes
`timescale 1ns/1ps
module emb_logic_cell_model (
   input wire logic use_global_i,
   input wire logic wr_req_i,
   input wire logic rd_req_i,
   output logic wstb_local_o,
   output logic wstb_global_o,
   output logic rstb_local_o,
   output logic rstb_global_o
);
   // strobe on chosen source
   // the idle source carries the inverse, so a wrong source select shows up at once
   assign wstb_local_o = use_global_i ? ~wr_req_i : wr_req_i;
   assign wstb_global_o = use_global_i ? wr_req_i : ~wr_req_i;
   assign rstb_local_o = use_global_i ? ~rd_req_i : rd_req_i;
   assign rstb_global_o = use_global_i ? rd_req_i : ~rd_req_i;
endmodule : emb_logic_cell_model

// file: emb_memory_block_tb.sv
// self-checking bench for the embedded memory block
`timescale 1ns/1ps
module emb_memory_block_tb;
   import emb_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [EMB_DATA_W-1:0] wdat = '0;
   logic [EMB_DATA_W-1:0] rd_data;
   logic [EMB_ADDR_W-1:0] wad = '0;
   logic [EMB_ADDR_W-1:0] rad = '0;
   logic wr_req = 1'b0, rd_req = 1'b0, use_gl = 1'b0, ice = 1'b0, oce = 1'b0, iclr = 1'b0;
   logic [2:0] clr_v = '0;
   logic [3:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdat, rdata;
   logic [1:0] resp, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, wsl, wsg, rsl, rsg;
   logic [7:0] modes [5] = '{8'h00, 8'h3F, 8'h40, 8'h80, 8'hFF};
   logic [15:0] exp_d;
   int error_cnt = 0, cmp_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   emb_logic_cell_model i_cells (.use_global_i(use_gl), .wr_req_i(wr_req), .rd_req_i(rd_req),
      .wstb_local_o(wsl), .wstb_global_o(wsg), .rstb_local_o(rsl), .rstb_global_o(rsg));
   emb_memory_block i_dut (.sys_clk_i(sys_clk), .reset_i(rst), .wr_data_i(wdat), .wr_addr_i(wad),
      .rd_addr_i(rad), .write_strobe_local_i(wsl), .write_strobe_global_i(wsg),
      .read_strobe_local_i(rsl), .read_strobe_global_i(rsg), .in_ce_i(ice), .out_ce_i(oce),
      .in_clr_local_i(iclr), .out_clr_local_i(clr_v[0]), .clr_global_i(clr_v[1]), .dev_clr_i(clr_v[2]),
      .rd_data_o(rd_data), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic report_and_stop();
      if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk);
         if (awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      while (bvalid !== 1'b1) @(posedge sys_clk);
      r = bresp;
      bready <= 1'b0;
      // one idle edge so a following call never re-drives bready in this time step
      @(posedge sys_clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge sys_clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask : axi_rd
   // the idle edge with enable high flushes the registered strobe before enable drops
   task automatic mem_wr(input logic [7:0] a, input logic [15:0] d, input logic ce);
      wad <= a; wdat <= d; wr_req <= 1'b1; ice <= ce;
      repeat (2) @(posedge sys_clk);
      wr_req <= 1'b0;
      @(posedge sys_clk);
      ice <= 1'b0;
      @(posedge sys_clk);
   endtask : mem_wr
   task automatic mem_rd(input logic [7:0] wa, input logic [7:0] ra, input int n, input logic oc,
         input logic [15:0] e);
      wad <= wa; rad <= ra; rd_req <= 1'b1; ice <= 1'b1; oce <= oc;
      repeat (n) @(posedge sys_clk);
      #1 check("rd_data", 32'(rd_data), 32'(e));
      @(posedge sys_clk);
      rd_req <= 1'b0; ice <= 1'b0; oce <= 1'b0;
      @(posedge sys_clk);
   endtask : mem_rd
   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      axi_rd(EMB_CTRL_OFS, rdat, resp);
      check("ctrl_reset", rdat, 32'(EMB_CTRL_RST));
      check("rd_reset", 32'(rd_data), EMB_ZERO32);
      axi_wr(4'h8, 32'h0000_00FF, resp);
      check("wr_unmapped", 32'(resp), 32'(EMB_RESP_SLVERR));
      axi_rd(4'hC, rdat, resp);
      check("rd_unmapped", {rdat[29:0], resp}, 32'(EMB_RESP_SLVERR));
      axi_wr(EMB_STATUS_OFS, 32'h0000_0001, resp);
      check("wr_status", 32'(resp), 32'(EMB_RESP_SLVERR));
      for (int i = 0; i < 5; i++) begin
         axi_wr(EMB_CTRL_OFS, 32'(modes[i]), resp);
         axi_rd(EMB_CTRL_OFS, rdat, resp);
         check("ctrl_rb", rdat, 32'(modes[i]));
         use_gl <= modes[i][EMB_STB_GLOBAL];
         exp_d = 16'h1000 + 16'(i) * 16'h0111;
         mem_wr(8'(i + 16), exp_d, 1'b1);
         mem_rd(modes[i][EMB_SINGLE_PORT] ? 8'(i + 16) : 8'h05, modes[i][EMB_SINGLE_PORT] ? 8'h05 : 8'(i + 16),
            (modes[i][5:0] == 6'h3F) ? 1 : 2, 1'b1, exp_d);
      end
      axi_rd(EMB_STATUS_OFS, rdat, resp);
      check("status", rdat, 32'(exp_d));
      axi_wr(EMB_CTRL_OFS, EMB_ZERO32, resp);
      use_gl <= 1'b0;
      mem_wr(8'h20, 16'h1234, 1'b1);
      mem_wr(8'h20, 16'hBEEF, 1'b0);
      mem_rd(8'h05, 8'h20, 2, 1'b1, 16'h1234);
      mem_rd(8'h05, 8'h10, 2, 1'b0, 16'h1234);
      for (int i = 0; i < 3; i++) begin
         mem_rd(8'h05, 8'h20, 2, 1'b1, 16'h1234);
         clr_v <= 3'(1 << i);
         @(posedge sys_clk);
         #1 check("clear", 32'(rd_data), EMB_ZERO32);
         @(posedge sys_clk);
         clr_v <= 3'h0;
      end
      mem_rd(8'h05, 8'h20, 2, 1'b1, 16'h1234);
      iclr <= 1'b1;
      @(posedge sys_clk);
      #1 check("in_clear", 32'(rd_data), 32'h0000_1234);
      @(posedge sys_clk);
      iclr <= 1'b0;
      report_and_stop();
   end
endmodule : emb_memory_block_tb
